// file: src/codec_ctrl_pkg.sv
// Constants and types for the codec control register bank
package codec_ctrl_pkg;

    // Serial control frame layout
    localparam int FRAME_BITS = 16;
    localparam int HEAD_BITS = 8;
    localparam int HI_BIT = 15;
    localparam int LO_BIT = 14;
    localparam int RW_BIT = 13;
    localparam int ADDR_MSB = 12;
    localparam int ADDR_LSB = 8;
    localparam int DATA_MSB = 7;

    // Register addresses and reset value
    localparam logic [4:0] SYS_CTRL_ADDR = 5'h01;
    localparam logic [4:0] GAIN_CTRL_ADDR = 5'h02;
    localparam logic [7:0] REG_RESET = 8'h00;

    // Field positions in system_control
    localparam int SYS_RST_BIT = 7;
    localparam int SYS_PD_BIT = 6;
    localparam int SYS_DLB_BIT = 5;
    localparam int SYS_ALB_BIT = 4;
    localparam int SYS_MSRC_BIT = 3;
    localparam int SYS_MGAIN_MSB = 2;

    // Field positions in gain_control
    localparam int GAIN_RX_MSB = 7;
    localparam int GAIN_RX_LSB = 5;
    localparam int GAIN_DAC_MSB = 4;
    localparam int GAIN_DAC_LSB = 2;
    localparam int GAIN_SPK_BIT = 1;

    typedef struct packed {
        logic soft_reset;
        logic power_down;
        logic digital_loop;
        logic analog_loop;
        logic monitor_src_rx;
        logic [2:0] monitor_gain;
    } sys_ctrl_t;

    typedef struct packed {
        logic [2:0] line_receive_input_gain;
        logic [2:0] dac_gain;
        logic speaker_en;
        logic adc_overflow;
    } gain_ctrl_t;

    typedef struct packed {
        logic sclk;
        logic frame_n;
        logic din;
    } serial_in_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HEAD = 2'b01,
        ST_BODY = 2'b11,
        ST_DONE = 2'b10
    } frame_state_t;

endpackage

// file: src/codec_ctrl_regs.sv
// Serial control frame decoder with the two codec control registers
//
// Behaviour
// (RL1) D12-D8 address, D7-D0 data byte
// (RL2) D13 low writes, high reads
// (RL3) D15,D14 low; addresses 1 and 2
// (RL4) System bit 7 holds soft reset
// (RL5) System bit 6 enters power-down
// (RL6) System bit 5 enables digital loopback
// (RL7) System bit 4 enables analog loopback
// (RL8) System bit 3 selects monitor source
// (RL9) System bits 2-0 set monitor gain
// (RL10) Gain bits 7-5 set receive gain
// (RL11) Gain bits 4-2 set DAC gain
// (RL12) Gain bit 1 enables speaker driver
// (RL13) Gain bit 0 shows ADC overflow
// (RL14) Both registers reset to zero
// (RL15) Reads return register byte; overflow unwritable
// (RL16) Other addresses leave registers unchanged
module codec_ctrl_regs
    import codec_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire serial_in_t ser_in,
    input wire logic control_slot,
    input wire logic adc_overflow_in,
    output logic dout,
    output logic dout_oe,
    output sys_ctrl_t sys_ctrl,
    output gain_ctrl_t gain_ctrl
);

    // Pin synchronisers: first stage read only by second
    serial_in_t sync1_q;
    serial_in_t sync2_q;
    logic ovf1_q;
    logic ovf2_q;
    logic sclk_prev_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_q <= '{sclk: 1'b0, frame_n: 1'b1, din: 1'b0};
            sync2_q <= '{sclk: 1'b0, frame_n: 1'b1, din: 1'b0};
            ovf1_q <= 1'b0;
            ovf2_q <= 1'b0;
            sclk_prev_q <= 1'b0;
        end else begin
            sync1_q <= ser_in;
            sync2_q <= sync1_q;
            ovf1_q <= adc_overflow_in;
            ovf2_q <= ovf1_q;
            sclk_prev_q <= sync2_q.sclk;
        end
    end

    logic in_frame;
    logic sclk_fall;
    logic sclk_rise;

    assign in_frame = !sync2_q.frame_n;
    assign sclk_fall = sclk_prev_q && !sync2_q.sclk;
    assign sclk_rise = !sclk_prev_q && sync2_q.sclk;

    // Frame state
    frame_state_t state_q;
    frame_state_t state_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [14:0] shreg_q;
    logic [14:0] shreg_d;
    logic read_q;
    logic read_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic dout_q;
    logic dout_d;
    logic oe_q;
    logic oe_d;
    sys_ctrl_t sys_q;
    sys_ctrl_t sys_d;
    gain_ctrl_t gain_q;
    gain_ctrl_t gain_d;

    logic [15:0] frame_w;
    logic [7:0] head_w;
    logic head_ok;
    logic last_bit;
    logic head_bit;
    logic wr_sys;
    logic wr_gain;

    assign frame_w = {shreg_q, sync2_q.din};
    assign head_w = frame_w[7:0];
    assign last_bit = sclk_fall && in_frame && cnt_q == 4'(FRAME_BITS - 1);
    assign head_bit = sclk_fall && in_frame && cnt_q == 4'(HEAD_BITS - 1);
    // Top two bits must be low to count as a control frame
    assign head_ok = control_slot && !frame_w[HI_BIT] && !frame_w[LO_BIT]; // RL3
    // A frame cut short never reaches last_bit and so writes nothing
    assign wr_sys = last_bit && head_ok && !frame_w[RW_BIT]
        && frame_w[ADDR_MSB:ADDR_LSB] == SYS_CTRL_ADDR; // RL2
    assign wr_gain = last_bit && head_ok && !frame_w[RW_BIT]
        && frame_w[ADDR_MSB:ADDR_LSB] == GAIN_CTRL_ADDR; // RL16

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        shreg_d = shreg_q;
        read_d = read_q;
        rdata_d = rdata_q;
        dout_d = dout_q;
        oe_d = in_frame;
        if (!in_frame) begin
            state_d = ST_IDLE;
            cnt_d = 4'h0;
            read_d = 1'b0;
            dout_d = 1'b0;
        end else begin
            // Extra bit clocks after the sixteenth bit are ignored
            if (sclk_fall && state_q != ST_DONE) begin
                shreg_d = frame_w[14:0]; // RL1
                cnt_d = cnt_q + 4'h1;
            end
            case (state_q)
                ST_IDLE: begin
                    state_d = ST_HEAD;
                end
                ST_HEAD: begin
                    if (head_bit) begin
                        state_d = ST_BODY;
                        // Header is complete: decide the read and latch its byte
                        read_d = control_slot && head_w[7:6] == 2'b00 && head_w[5]; // RL2
                        case (head_w[4:0])
                            SYS_CTRL_ADDR: rdata_d = sys_q; // RL15
                            GAIN_CTRL_ADDR: rdata_d = gain_q; // RL15
                            default: rdata_d = 8'h00; // RL16
                        endcase
                    end
                end
                ST_BODY: begin
                    if (last_bit) begin
                        state_d = ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_d = ST_DONE;
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
            // Output bits change on the rising edge, ahead of host sampling
            if (sclk_rise) begin
                if (state_q == ST_BODY && read_q) begin
                    dout_d = rdata_q[DATA_MSB]; // RL15
                    rdata_d = {rdata_q[6:0], 1'b0};
                end else begin
                    dout_d = 1'b0;
                end
            end
        end
    end

    always_comb begin
        sys_d = sys_q;
        gain_d = gain_q;
        if (wr_sys) begin
            sys_d.soft_reset = frame_w[SYS_RST_BIT]; // RL4
            sys_d.power_down = frame_w[SYS_PD_BIT]; // RL5
            sys_d.digital_loop = frame_w[SYS_DLB_BIT]; // RL6
            sys_d.analog_loop = frame_w[SYS_ALB_BIT]; // RL7
            sys_d.monitor_src_rx = frame_w[SYS_MSRC_BIT]; // RL8
            sys_d.monitor_gain = frame_w[SYS_MGAIN_MSB:0]; // RL9
        end
        if (wr_gain) begin
            gain_d.line_receive_input_gain = frame_w[GAIN_RX_MSB:GAIN_RX_LSB]; // RL10
            gain_d.dac_gain = frame_w[GAIN_DAC_MSB:GAIN_DAC_LSB]; // RL11
            gain_d.speaker_en = frame_w[GAIN_SPK_BIT]; // RL12
        end
        // Overflow bit follows the converter, never the host
        gain_d.adc_overflow = ovf2_q; // RL13
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            shreg_q <= 15'h0000;
            read_q <= 1'b0;
            rdata_q <= 8'h00;
            dout_q <= 1'b0;
            oe_q <= 1'b0;
            sys_q <= REG_RESET; // RL14
            gain_q <= REG_RESET; // RL14
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            shreg_q <= shreg_d;
            read_q <= read_d;
            rdata_q <= rdata_d;
            dout_q <= dout_d;
            oe_q <= oe_d;
            sys_q <= sys_d;
            gain_q <= gain_d;
        end
    end

    assign dout = dout_q;
    assign dout_oe = oe_q;
    assign sys_ctrl = sys_q;
    assign gain_ctrl = gain_q;

    // Checks

    a_write_sys: assert property (@(posedge clk) disable iff (rst) // RL1
        wr_sys |=> sys_q == $past(frame_w[7:0]))
        else $error("system_control write not stored");

    a_write_gain: assert property (@(posedge clk) disable iff (rst) // RL11
        wr_gain |=> gain_q[7:1] == $past(frame_w[7:1]))
        else $error("gain_control write not stored");

    a_read_nowrite: assert property (@(posedge clk) disable iff (rst) // RL2
        (last_bit && frame_w[RW_BIT]) |=> $stable(sys_q) && $stable(gain_q[7:1]))
        else $error("read frame changed a register");

    a_high_bits: assert property (@(posedge clk) disable iff (rst) // RL3
        (last_bit && (frame_w[HI_BIT] || frame_w[LO_BIT])) |=> $stable(sys_q))
        else $error("frame with D15/D14 set was taken");

    a_bad_addr: assert property (@(posedge clk) disable iff (rst) // RL16
        (last_bit && frame_w[ADDR_MSB:ADDR_LSB] != SYS_CTRL_ADDR
        && frame_w[ADDR_MSB:ADDR_LSB] != GAIN_CTRL_ADDR)
        |=> $stable(sys_q) && $stable(gain_q[7:1]))
        else $error("unmapped address changed a register");

    a_ovf_track: assert property (@(posedge clk) disable iff (rst) // RL13
        ##2 gain_q.adc_overflow == $past(ovf1_q, 2))
        else $error("overflow bit does not follow converter");

    a_read_latch: assert property (@(posedge clk) disable iff (rst) // RL15
        (head_bit && control_slot && head_w[7:5] == 3'b001 && head_w[4:0] == SYS_CTRL_ADDR)
        |=> read_q && rdata_q == $past(sys_q))
        else $error("read byte not latched from system_control");

    a_oe_frame: assert property (@(posedge clk) disable iff (rst) // RL15
        !in_frame |=> !dout_oe && !dout)
        else $error("serial output driven outside a frame");

    a_read_gain: assert property (@(posedge clk) disable iff (rst) // RL15
        (head_bit && control_slot && head_w[7:5] == 3'b001 && head_w[4:0] == GAIN_CTRL_ADDR)
        |=> read_q && rdata_q == $past(gain_q))
        else $error("read byte not latched from gain_control");

    a_read_refused: assert property (@(posedge clk) disable iff (rst) // RL3
        (head_bit && !(control_slot && head_w[7:5] == 3'b001))
        |=> !read_q)
        else $error("refused frame was treated as a read");

    a_bad_read: assert property (@(posedge clk) disable iff (rst) // RL16
        (head_bit && head_w[4:0] != SYS_CTRL_ADDR && head_w[4:0] != GAIN_CTRL_ADDR)
        |=> rdata_q == 8'h00)
        else $error("unmapped read returned register data");

    a_slot_low: assert property (@(posedge clk) disable iff (rst) // RL3
        (last_bit && !control_slot)
        |=> $stable(sys_q) && $stable(gain_q[7:1]))
        else $error("frame outside a control slot was taken");

    a_ovf_nowrite: assert property (@(posedge clk) disable iff (rst) // RL15
        wr_gain
        |=> gain_q.adc_overflow == $past(ovf2_q))
        else $error("host write reached the overflow bit");

    a_dout_quiet: assert property (@(posedge clk) disable iff (rst) // RL15
        !read_q
        |=> !dout)
        else $error("serial output carried data outside a read");

    a_done_hold: assert property (@(posedge clk) disable iff (rst) // RL1
        (state_q == ST_DONE && in_frame)
        |=> state_q == ST_DONE && $stable(shreg_q) && $stable(cnt_q))
        else $error("bit clock after the last bit was taken");

    a_no_early: assert property (@(posedge clk) disable iff (rst) // RL1
        !last_bit
        |=> $stable(sys_q) && $stable(gain_q[7:1]))
        else $error("register changed before the sixteenth bit");

    a_oe_inside: assert property (@(posedge clk) disable iff (rst) // RL15
        in_frame
        |=> dout_oe)
        else $error("serial output not driven inside a frame");

    a_head_body: assert property (@(posedge clk) disable iff (rst) // RL1
        head_bit
        |=> state_q == ST_BODY && cnt_q == 4'(HEAD_BITS))
        else $error("header end did not open the data byte");

    // Reset is checked without disable so that it is seen while it is held
    a_reset_zero: assert property (@(posedge clk) // RL14
        rst
        |=> sys_q == REG_RESET && gain_q == REG_RESET)
        else $error("registers not cleared by reset");

endmodule

// file: verif/codec_host.sv
// Host model driving control frames on the serial port
module codec_host
    import codec_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic dout,
    input wire logic dout_oe,
    output serial_in_t ser_in,
    output logic control_slot
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ser_in = '{sclk: 1'b0, frame_n: 1'b1, din: 1'b0};
        control_slot = 1'b0;
    end
    // Bit clock stays low between frames; data changes on the rise
    // Fewer than sixteen bits gives a frame cut short
    task automatic frame(input logic [15:0] w, input logic slot, input int nbits, output logic [7:0] rd,
        output logic oe_ok);
        oe_ok = 1'b1;
        @(posedge clk);
        ser_in.frame_n <= 1'b0;
        control_slot <= slot;
        repeat (8) @(posedge clk);
        for (int i = 15; i > 15 - nbits; i--) begin
            ser_in.sclk <= 1'b1;
            ser_in.din <= w[i];
            repeat (7) @(posedge clk);
            #1;
            // A released output reads as the inverse of what was last driven
            if (i < 8) rd[i] = dout_oe ? dout : ~dout;
            oe_ok &= dout_oe;
            @(posedge clk);
            ser_in.sclk <= 1'b0;
            repeat (8) @(posedge clk);
        end
        ser_in.frame_n <= 1'b1;
        // Released line shows no stale value
        ser_in.din <= ~ser_in.din;
        control_slot <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
endmodule

// file: verif/tb_codec_ctrl_regs.sv
// Self-checking bench for the codec control register bank
module tb_codec_ctrl_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import codec_ctrl_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic adc_overflow_in = 1'b0;
    logic control_slot, dout, dout_oe, oe_ok;
    logic [7:0] rd;
    serial_in_t ser_in;
    sys_ctrl_t sys_ctrl;
    gain_ctrl_t gain_ctrl;
    int num_errors = 0;
    int comparisons = 0;
    always #5 clk = ~clk;
    codec_ctrl_regs codec_ctrl_regs_i(.clk(clk), .rst(rst), .ser_in(ser_in), .control_slot(control_slot),
        .adc_overflow_in(adc_overflow_in), .dout(dout), .dout_oe(dout_oe), .sys_ctrl(sys_ctrl),
        .gain_ctrl(gain_ctrl));
    codec_host codec_host_i(.clk(clk), .dout(dout), .dout_oe(dout_oe), .ser_in(ser_in),
        .control_slot(control_slot));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic send(input logic [15:0] w, input logic slot);
        codec_host_i.frame(w, slot, 16, rd, oe_ok);
    endtask
    // Write a register, check it, then read it back
    task automatic wr_rd(input logic [4:0] a, input logic [7:0] v, input logic [7:0] exp);
        send({3'b000, a, v}, 1'b1);
        chk((a == SYS_CTRL_ADDR) ? sys_ctrl : gain_ctrl, exp, "write");
        send({3'b001, a, 8'h00}, 1'b1);
        chk(rd, exp, "read back");
        chk({7'h00, oe_ok}, 8'h01, "dout enable");
    endtask
    task automatic test_reset();
        chk(sys_ctrl, REG_RESET, "sys reset");
        chk(gain_ctrl, REG_RESET, "gain reset");
        chk({6'h00, dout_oe, dout}, 8'h00, "idle pins");
        $display("test_reset done");
    endtask
    task automatic test_sys();
        wr_rd(SYS_CTRL_ADDR, 8'hA5, 8'hA5);
        wr_rd(SYS_CTRL_ADDR, 8'h5A, 8'h5A);
        $display("test_sys done");
    endtask
    task automatic test_gain();
        wr_rd(GAIN_CTRL_ADDR, 8'h6B, 8'h6A);
        wr_rd(GAIN_CTRL_ADDR, 8'h91, 8'h90);
        $display("test_gain done");
    endtask
    task automatic test_refuse();
        logic [15:0] w[4] = '{16'h03FF, 16'h81FF, 16'h41FF, 16'h1FFF};
        foreach (w[k]) send(w[k], 1'b1);
        send(16'h01FF, 1'b0);
        codec_host_i.frame(16'h01FF, 1'b1, 12, rd, oe_ok);
        chk(sys_ctrl, 8'h5A, "sys kept");
        chk(gain_ctrl, 8'h90, "gain kept");
        send(16'h2300, 1'b1);
        chk(rd, 8'h00, "unmapped read");
        send(16'hA100, 1'b1);
        chk(rd, 8'h00, "high bit read");
        send(16'h2100, 1'b0);
        chk(rd, 8'h00, "off-slot read");
        $display("test_refuse done");
    endtask
    task automatic test_ovf();
        @(posedge clk);
        adc_overflow_in <= 1'b1;
        repeat (5) @(posedge clk);
        chk(gain_ctrl, 8'h91, "overflow flag");
        send(16'h2200, 1'b1);
        chk(rd, 8'h91, "overflow read");
        adc_overflow_in <= 1'b0;
        repeat (5) @(posedge clk);
        chk(gain_ctrl, 8'h90, "overflow gone");
        $display("test_ovf done");
    endtask
    task automatic test_rst_mid();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        test_reset();
        rst <= 1'b0;
        wr_rd(SYS_CTRL_ADDR, 8'h01, 8'h01);
        $display("test_rst_mid done");
    endtask
    task automatic wrap_up();
        $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        test_reset();
        test_sys();
        test_gain();
        test_refuse();
        test_ovf();
        test_rst_mid();
        wrap_up();
    end
    // About twenty frames of 273 cycles each
    initial begin
        #200us;
        num_errors++;
        wrap_up();
    end
endmodule
